/* bench/compare_force_and_counter_tb.sv */
`include "cfc_defines.svh"
`define CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module compare_force_and_counter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, test_mode, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, v1;
   logic [3:0] pstrb;
   logic [7:0] timer_pin, timer_pin_oe_n;
   logic err;
   int n_fail = 0;
   int comparisons = 0;

   cfc_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .test_mode(test_mode), .timer_pin(timer_pin), .timer_pin_oe_n(timer_pin_oe_n), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // request held until pready is seen high; no fixed wait state assumed
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) n_fail++;
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge pclk);
      #1;
   endtask

   task automatic t_reset();
      tick(1);
      `CHECK("pins", 8'h00, timer_pin)
      `CHECK("pin enables", 8'hff, timer_pin_oe_n)
      apb(1'b0, `CFC_OFS_MASK7, 32'h0);
      `CHECK("mask7 reset", 8'h00, q[7:0])
      $display("test reset done");
   endtask

   task automatic t_force();
      apb(1'b1, `CFC_OFS_SELECT, 32'h0000_00fe);
      apb(1'b1, `CFC_OFS_DISC, 32'h0000_0004);
      apb(1'b1, `CFC_OFS_ACTION, 32'h0000_0300);
      tick(2);
      `CHECK("pin enables", 8'h05, timer_pin_oe_n)
      apb(1'b1, `CFC_OFS_FORCE, 32'h0000_0000);
      tick(2);
      `CHECK("pins zero force", 8'h00, timer_pin)
      apb(1'b1, `CFC_OFS_FORCE, 32'h0000_0010);
      tick(2);
      `CHECK("pins force4", 8'h10, timer_pin)
      apb(1'b0, `CFC_OFS_FORCE, 32'h0);
      `CHECK("force readback", 32'h0000_0000, q)
      apb(1'b0, `CFC_OFS_FLAGS, 32'h0);
      `CHECK("compare flags", 8'h00, q[7:0])
      $display("test force done");
   endtask

   task automatic t_seven();
      apb(1'b1, `CFC_OFS_MASK7, 32'h0000_000f);
      apb(1'b1, `CFC_OFS_DATA7, 32'h0000_000f);
      apb(1'b1, `CFC_OFS_FORCE, 32'h0000_0080);
      tick(2);
      // ch0 is capture, ch2 disconnected: neither may take its data bit
      `CHECK("pins ch7 force", 8'h1a, timer_pin)
      apb(1'b0, `CFC_OFS_DATA7, 32'h0);
      `CHECK("data7 readback", 8'h0f, q[7:0])
      $display("test seven done");
   endtask

   task automatic t_counter();
      apb(1'b1, `CFC_OFS_COUNTER, 32'h0000_abcd);
      apb(1'b0, `CFC_OFS_COUNTER, 32'h0);
      `CHECK("counter normal write", 16'h0000, q[15:0])
      test_mode <= 1'b1;
      tick(4);
      apb(1'b1, `CFC_OFS_COUNTER, 32'h0000_fff0);
      apb(1'b0, `CFC_OFS_COUNTER, 32'h0);
      `CHECK("counter test load", 16'hfff0, q[15:0])
      apb(1'b0, 12'h014, 32'h0);
      `CHECK("unmapped error", 1'b1, err)
      $display("test counter done");
   endtask

   task automatic t_overflow();
      int n;
      apb(1'b1, `CFC_OFS_MASK7, 32'h0000_0018);
      apb(1'b1, `CFC_OFS_DATA7, 32'h0000_0000);
      apb(1'b1, `CFC_OFS_TOGGLE, 32'h0000_00b0);
      apb(1'b1, `CFC_OFS_IMASK, 32'h0000_0001);
      apb(1'b1, `CFC_OFS_CONTROL, 32'h0000_0080);
      n = 0;
      while (irq !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      `CHECK("irq raised", 1'b1, irq)
      // ch4 masked: data7 wins over its toggle; ch5, ch7 toggle
      `CHECK("pins overflow", 8'ha2, timer_pin)
      apb(1'b0, `CFC_OFS_COUNTER, 32'h0);
      v1 = q;
      apb(1'b0, `CFC_OFS_COUNTER, 32'h0);
      // the two reads sample four clocks apart, one tick per clock
      `CHECK("counter counts up", 16'h0004, 16'(q[15:0] - v1[15:0]))
      apb(1'b0, `CFC_OFS_STATUS, 32'h0);
      `CHECK("overflow status", 1'b1, q[`CFC_ST_OVF])
      apb(1'b0, `CFC_OFS_FLAGS, 32'h0);
      `CHECK("match flags", 8'hfe, q[7:0])
      apb(1'b1, `CFC_OFS_IMASK, 32'h0);
      tick(2);
      `CHECK("irq masked", 1'b0, irq)
      apb(1'b1, `CFC_OFS_STATUS, 32'h0000_000f);
      apb(1'b1, `CFC_OFS_IMASK, 32'h0000_0001);
      tick(2);
      `CHECK("irq cleared", 1'b0, irq)
      $display("test overflow done");
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      test_mode = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_force();
      t_seven();
      t_counter();
      t_overflow();
      close_out();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      close_out();
   end
endmodule // compare_force_and_counter_tb

/* src/cfc_defines.svh */
`ifndef CFC_DEFINES_SVH
`define CFC_DEFINES_SVH
// byte-address offsets of the 32-bit register words
`define CFC_OFS_SELECT    12'h000
`define CFC_OFS_FORCE     12'h004
`define CFC_OFS_MASK7     12'h008
`define CFC_OFS_DATA7     12'h00c
`define CFC_OFS_COUNTER   12'h010
`define CFC_OFS_CONTROL   12'h018
`define CFC_OFS_TOGGLE    12'h01c
`define CFC_OFS_ACTION    12'h020
`define CFC_OFS_FLAGS     12'h038
`define CFC_OFS_MODE      12'h03c
`define CFC_OFS_DISC      12'h040
`define CFC_OFS_STATUS    12'h044
`define CFC_OFS_IMASK     12'h048
`define CFC_OFS_CMP_BASE  12'h080
// control register fields
`define CFC_CTL_TEN       7
`define CFC_CTL_PRE_LSB   0
// status bits of the interrupt register
`define CFC_ST_OVF        0
`define CFC_ST_CH7        1
`define CFC_ST_FORCE      2
`define CFC_ST_W          3
`define CFC_RST_BYTE      8'h00
`define CFC_RST_COUNT     16'h0000
`define CFC_PRE_W         3
`endif

/* src/cfc_pkg.sv */
package cfc_pkg;
   typedef enum logic [1:0] {
      cfc_act_none = 2'b00,
      cfc_act_toggle = 2'b01,
      cfc_act_clear = 2'b10,
      cfc_act_set = 2'b11
   } cfc_act_e;
   typedef struct packed {
      logic [7:0] select;
      logic [7:0] mask7;
      logic [7:0] data7;
      logic [7:0] toggle;
      logic [7:0] disc;
   } cfc_cfg_s;
endpackage : cfc_pkg

/* src/cfc_timer.sv */
// Register access over APB and the address map were decided locally.
`include "cfc_defines.svh"

// Functional notes
// - force register always reads as zero
// - force bit performs channel compare pin action
// - forced compare never sets compare flag
// - channel seven event overrides channels six-zero
// - force beats real match, flag stays clear
// - masked channels copy seven-data bit to pin
// - transfer only when compare mode, not disconnected
// - sixteen-bit up counter on prescaled tick
// - counter writable only in test mode
// - first period after load may differ
// - select bit one means output compare
// - overflow toggle beats force, not channel seven
// - timer enable zero stops the counter
module cfc_timer
   import cfc_pkg::*;
#(
   parameter int NCH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic test_mode,
   output logic [7:0] timer_pin,
   output logic [7:0] timer_pin_oe_n,
   output logic irq
);
   if (NCH != 8) begin : g_nch_check
      $error("only eight channels are supported");
   end

   logic test_q1, test_q2;
   cfc_cfg_s cfg, next_cfg;
   logic [15:0] action, next_action;
   logic [7:0] cmp_flag, next_cmp_flag;
   logic [7:0] ctrl, next_ctrl;
   logic [15:0] main_counter, next_main_counter;
   logic [15:0] cmp_val [8];
   logic [15:0] next_cmp_val [8];
   // seven bits reach the largest divide, 2^7
   logic [6:0] pre_cnt, next_pre_cnt;
   logic [7:0] pin, next_pin;
   logic [`CFC_ST_W-1:0] status, next_status, imask, next_imask;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, next_irq;

   logic wr, rd, tick, ovf, ch7_event, timer_enable_bit;
   logic acc;
   logic [7:0] force_bit, match, normal_hit;

   function automatic logic [7:0] apply_byte(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
      return s[0] ? d[7:0] : old;
   endfunction

   function automatic logic pin_action(input logic cur, input logic [1:0] a);
      unique case (cfc_act_e'(a))
         cfc_act_none: return cur;
         cfc_act_toggle: return ~cur;
         cfc_act_clear: return 1'b0;
         cfc_act_set: return 1'b1;
      endcase
   endfunction

   // test mode arrives from outside the clock domain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_q1 <= 1'b0;
         test_q2 <= 1'b0;
      end else begin
         test_q1 <= test_mode;
         test_q2 <= test_q1;
      end
   end

   // answer after one access cycle; writes commit only at the completing edge
   assign acc = psel && penable && !pready;
   assign wr = psel && penable && pwrite && pready;
   assign rd = acc && !pwrite;
   assign timer_enable_bit = ctrl[`CFC_CTL_TEN];

   // prescaler: tick every 2^pre clocks
   always_comb begin
      next_pre_cnt = pre_cnt;
      tick = 1'b0;
      if (timer_enable_bit) begin
         next_pre_cnt = pre_cnt + 7'h01;
         tick = (pre_cnt == ((7'h01 << ctrl[`CFC_PRE_W-1:0]) - 7'h01))
            || (ctrl[`CFC_PRE_W-1:0] == '0);
         if (tick) next_pre_cnt = '0;
      end
   end

   assign ovf = tick && (main_counter == 16'hffff);

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         match[i] = tick && cfg.select[i] && (cmp_val[i] == main_counter + 16'h0001);
      end
      // written ones only; zeros do nothing
      force_bit = (wr && paddr == `CFC_OFS_FORCE && pstrb[0]) ? pwdata[7:0] : 8'h00;
      ch7_event = match[7] || (ovf && cfg.toggle[7]) || force_bit[7];
      normal_hit = match & ~force_bit;
   end

   // pin update: ch7 mask > overflow toggle > force > compare match
   always_comb begin
      next_pin = pin;
      for (int i = 0; i < 8; i++) begin
         if (cfg.select[i] && !cfg.disc[i]) begin
            if (ch7_event && cfg.mask7[i]) begin
               next_pin[i] = cfg.data7[i];
            end else if (ovf && cfg.toggle[i]) begin
               next_pin[i] = ~pin[i];
            end else if (force_bit[i] || match[i]) begin
               next_pin[i] = pin_action(pin[i], action[2*i +: 2]);
            end
         end
      end
   end

   // counter and registers
   always_comb begin
      next_cfg = cfg;
      next_action = action;
      next_ctrl = ctrl;
      next_imask = imask;
      next_cmp_val = cmp_val;
      next_main_counter = main_counter;
      next_cmp_flag = cmp_flag | normal_hit;
      next_status = status;
      if (tick) next_main_counter = main_counter + 16'h0001;
      if (wr) begin
         unique case (paddr)
            `CFC_OFS_SELECT: next_cfg.select = apply_byte(cfg.select, pwdata, pstrb);
            `CFC_OFS_MASK7: next_cfg.mask7 = apply_byte(cfg.mask7, pwdata, pstrb);
            `CFC_OFS_DATA7: next_cfg.data7 = apply_byte(cfg.data7, pwdata, pstrb);
            `CFC_OFS_TOGGLE: next_cfg.toggle = apply_byte(cfg.toggle, pwdata, pstrb);
            `CFC_OFS_MODE: next_cfg.disc = apply_byte(cfg.disc, pwdata, pstrb);
            `CFC_OFS_CONTROL: next_ctrl = apply_byte(ctrl, pwdata, pstrb);
            `CFC_OFS_DISC: next_cfg.disc = apply_byte(cfg.disc, pwdata, pstrb);
            `CFC_OFS_IMASK: next_imask = pstrb[0] ? pwdata[`CFC_ST_W-1:0] : imask;
            `CFC_OFS_ACTION: begin
               if (pstrb[0]) next_action[7:0] = pwdata[7:0];
               if (pstrb[1]) next_action[15:8] = pwdata[15:8];
            end
            `CFC_OFS_FLAGS: begin
               if (pstrb[0]) next_cmp_flag = (cmp_flag & ~pwdata[7:0]) | normal_hit;
            end
            `CFC_OFS_COUNTER: begin
               // load ignored outside test mode; prescaler phase is not reset
               if (test_q2) begin
                  if (pstrb[0]) next_main_counter[7:0] = pwdata[7:0];
                  if (pstrb[1]) next_main_counter[15:8] = pwdata[15:8];
               end
            end
            default: begin
               if (paddr >= `CFC_OFS_CMP_BASE && paddr < `CFC_OFS_CMP_BASE + 12'h020 && paddr[1:0] == 2'b00) begin
                  if (pstrb[0]) next_cmp_val[paddr[4:2]][7:0] = pwdata[7:0];
                  if (pstrb[1]) next_cmp_val[paddr[4:2]][15:8] = pwdata[15:8];
               end
            end
         endcase
      end
      if (wr && paddr == `CFC_OFS_STATUS && pstrb[0]) begin
         next_status = status & ~pwdata[`CFC_ST_W-1:0];
      end
      // set wins over write-one clear
      if (ovf) next_status[`CFC_ST_OVF] = 1'b1;
      if (ch7_event) next_status[`CFC_ST_CH7] = 1'b1;
      if (|force_bit) next_status[`CFC_ST_FORCE] = 1'b1;
      next_irq = |(next_status & imask);
   end

   // read mux; one wait state free answer, unmapped gives slverr
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      next_pready = psel && penable && !pready;
      if (acc) begin
         unique case (paddr)
            `CFC_OFS_SELECT: next_prdata[7:0] = cfg.select;
            `CFC_OFS_FORCE: next_prdata = 32'h0000_0000;
            `CFC_OFS_MASK7: next_prdata[7:0] = cfg.mask7;
            `CFC_OFS_DATA7: next_prdata[7:0] = cfg.data7;
            `CFC_OFS_COUNTER: next_prdata[15:0] = main_counter;
            `CFC_OFS_CONTROL: next_prdata[7:0] = ctrl;
            `CFC_OFS_TOGGLE: next_prdata[7:0] = cfg.toggle;
            `CFC_OFS_ACTION: next_prdata[15:0] = action;
            `CFC_OFS_FLAGS: next_prdata[7:0] = cmp_flag;
            `CFC_OFS_MODE: next_prdata[7:0] = cfg.disc;
            `CFC_OFS_DISC: next_prdata[7:0] = cfg.disc;
            `CFC_OFS_STATUS: next_prdata[`CFC_ST_W-1:0] = status;
            `CFC_OFS_IMASK: next_prdata[`CFC_ST_W-1:0] = imask;
            default: begin
               if (paddr >= `CFC_OFS_CMP_BASE && paddr < `CFC_OFS_CMP_BASE + 12'h020 && paddr[1:0] == 2'b00) begin
                  next_prdata[15:0] = cmp_val[paddr[4:2]];
               end else begin
                  next_pslverr = 1'b1;
               end
            end
         endcase
         if (pwrite) next_prdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= '0;
         action <= '0;
         ctrl <= `CFC_RST_BYTE;
         imask <= '0;
         status <= '0;
         cmp_flag <= `CFC_RST_BYTE;
         main_counter <= `CFC_RST_COUNT;
         pre_cnt <= '0;
         pin <= `CFC_RST_BYTE;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
         timer_pin <= `CFC_RST_BYTE;
         timer_pin_oe_n <= 8'hff;
         for (int i = 0; i < 8; i++) cmp_val[i] <= 16'h0000;
      end else begin
         cfg <= next_cfg;
         action <= next_action;
         ctrl <= next_ctrl;
         imask <= next_imask;
         status <= next_status;
         cmp_flag <= next_cmp_flag;
         main_counter <= next_main_counter;
         pre_cnt <= next_pre_cnt;
         pin <= next_pin;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         irq <= next_irq;
         timer_pin <= next_pin;
         timer_pin_oe_n <= ~(next_cfg.select & ~next_cfg.disc);
         cmp_val <= next_cmp_val;
      end
   end

   a_force_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && paddr == `CFC_OFS_FORCE) |=> (prdata == 32'h0000_0000))
      else $error("force register read not zero");
   a_force_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (force_bit[4] && !cmp_flag[4] && !(wr && paddr == `CFC_OFS_FLAGS)) |=> !cmp_flag[4])
      else $error("forced compare set a flag");
   a_ch7_copy: assert property (@(posedge pclk) disable iff (!presetn)
      (ch7_event && cfg.mask7[3] && cfg.select[3] && !cfg.disc[3]) |=> (pin[3] == $past(cfg.data7[3])))
      else $error("channel seven data not copied");
   a_ch7_blocked: assert property (@(posedge pclk) disable iff (!presetn)
      (!cfg.select[2] || cfg.disc[2]) |=> $stable(pin[2]))
      else $error("pin changed while not compare output");
   a_counter_up: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !wr) |=> (main_counter == $past(main_counter) + 16'h0001))
      else $error("counter failed to advance");
   a_counter_locked: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == `CFC_OFS_COUNTER && !test_q2 && !tick) |=> $stable(main_counter))
      else $error("counter written outside test mode");
   a_disabled_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (!timer_enable_bit && !wr) [*2] |-> $stable(main_counter))
      else $error("counter moved while disabled");
   a_ovf_toggle: assert property (@(posedge pclk) disable iff (!presetn)
      (ovf && cfg.toggle[5] && cfg.select[5] && !cfg.disc[5] && !(ch7_event && cfg.mask7[5]))
      |=> (pin[5] != $past(pin[5])))
      else $error("overflow toggle missing");
   a_force_action: assert property (@(posedge pclk) disable iff (!presetn)
      (force_bit[4] && cfg.select[4] && !cfg.disc[4] && !ovf && !ch7_event && action[9:8] == 2'b11)
      |=> pin[4])
      else $error("forced set action missing");
   a_override_toggle: assert property (@(posedge pclk) disable iff (!presetn)
      (ch7_event && cfg.mask7[4] && cfg.select[4] && !cfg.disc[4]) |=> (pin[4] == $past(cfg.data7[4])))
      else $error("channel seven event did not win");
   a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (match[6] && !force_bit[6]) |=> cmp_flag[6])
      else $error("unforced match left flag clear");
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready stood more than one cycle");
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> (irq == |(status & $past(imask))))
      else $error("interrupt level wrong");
   c_force: cover property (@(posedge pclk) disable iff (!presetn) |force_bit);
   c_ch7: cover property (@(posedge pclk) disable iff (!presetn) ch7_event && |cfg.mask7);
   c_ovf: cover property (@(posedge pclk) disable iff (!presetn) ovf);
   c_match_flag: cover property (@(posedge pclk) disable iff (!presetn) |normal_hit);
   c_load: cover property (@(posedge pclk) disable iff (!presetn) wr && paddr == `CFC_OFS_COUNTER && test_q2);
endmodule : cfc_timer
